// ===== hdl/rtcnv_top.sv
/*
 * bcd clock/calendar with double-buffered user registers over a 2k byte store.
 * assumes host pins synchronous to sys_clk; data bus split into in, out, enable.
 */
`timescale 1ns/1ps
module rtcnv_top #(
    parameter int SEC_CYCLES     = rtcnv_pkg::SEC_CYCLES,
    parameter int FT_HALF_CYCLES = rtcnv_pkg::FT_HALF_CYCLES
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // host port
    input  wire logic [10:0] addr,
    input  wire logic        chip_sel_n,
    input  wire logic        out_en_n,
    input  wire logic        write_en_n,
    input  wire logic [7:0]  data_in,
    output logic      [7:0]  data_out,
    output logic             data_oe,
    // supply and battery status
    input  wire logic        power_fail,
    input  wire logic        battery_ok
);
    typedef struct packed {
        logic [7:0] cen, yr, mon, date, wday, hr, min, sec;
    } rtcnv_time_s;

    typedef struct packed {
        rtcnv_time_s cnt;      // internal count
        rtcnv_time_s usr;      // host-visible copy
        logic        load_hold;
        logic        snap_hold;
        logic        osc_stop;
        logic        freq_test;
        logic        ft_phase;
        logic [31:0] sec_div;
        logic [31:0] ft_div;
        logic        rd;
        logic        wr;
        logic [10:0] waddr;
        logic [7:0]  wdata;
        logic [10:0] raddr;
        logic [7:0]  dout;
        logic        doe;
    } rtcnv_state_s;

    rtcnv_state_s st_q, st_d;
    rtcnv_mem_if  mem_port ();

    initial begin
        if (SEC_CYCLES < 2 || FT_HALF_CYCLES < 1 || FT_HALF_CYCLES >= SEC_CYCLES)
            $error("timing counts out of range");
    end

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) bcd_inc = {v[7:4] + 4'h1, 4'h0};
        else bcd_inc = {v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic is_leap(input logic [7:0] yr);
        is_leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                        : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    endfunction

    function automatic logic [7:0] month_days(input logic [7:0] mon, input logic [7:0] yr);
        case (mon)
            8'h02:                      month_days = is_leap(yr) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
            default:                    month_days = 8'h31;
        endcase
    endfunction

    // one-second advance of the whole calendar
    function automatic rtcnv_time_s advance(input rtcnv_time_s t);
        rtcnv_time_s n;
        n = t;
        if (t.sec != rtcnv_pkg::MAX_SEC) return '{default: 8'h00, sec: bcd_inc(t.sec), min: t.min, hr: t.hr,
            wday: t.wday, date: t.date, mon: t.mon, yr: t.yr, cen: t.cen};
        n.sec = rtcnv_pkg::RST_ZERO;
        if (t.min != rtcnv_pkg::MAX_MIN) begin
            n.min = bcd_inc(t.min);
            return n;
        end
        n.min = rtcnv_pkg::RST_ZERO;
        if (t.hr != rtcnv_pkg::MAX_HOUR) begin
            n.hr = bcd_inc(t.hr);
            return n;
        end
        n.hr = rtcnv_pkg::RST_ZERO;
        n.wday = (t.wday == rtcnv_pkg::MAX_WDAY) ? rtcnv_pkg::RST_ONE : bcd_inc(t.wday);
        if (t.date != month_days(t.mon, t.yr)) begin
            n.date = bcd_inc(t.date);
            return n;
        end
        n.date = rtcnv_pkg::RST_ONE;
        if (t.mon != rtcnv_pkg::MAX_MONTH) begin
            n.mon = bcd_inc(t.mon);
            return n;
        end
        n.mon = rtcnv_pkg::RST_ONE;
        if (t.yr != rtcnv_pkg::MAX_YEAR) begin
            n.yr = bcd_inc(t.yr);
            return n;
        end
        n.yr = rtcnv_pkg::RST_ZERO;
        n.cen = (t.cen == rtcnv_pkg::MAX_CENT) ? rtcnv_pkg::RST_ZERO : bcd_inc(t.cen);
        return n;
    endfunction

    // host-visible byte of a clock register
    function automatic logic [7:0] rtc_byte(input logic [10:0] a, input rtcnv_state_s s, input logic batt);
        case (a)
            rtcnv_pkg::OFS_CONTROL: rtc_byte = {s.load_hold, s.snap_hold, s.usr.cen[5:0]};
            rtcnv_pkg::OFS_SECONDS: rtc_byte = {s.osc_stop, s.usr.sec[6:1],
                                                (s.freq_test && !s.osc_stop) ? s.ft_phase : s.usr.sec[0]};
            rtcnv_pkg::OFS_MINUTES: rtc_byte = s.usr.min;
            rtcnv_pkg::OFS_HOURS:   rtc_byte = s.usr.hr;
            rtcnv_pkg::OFS_WEEKDAY: rtc_byte = {batt, s.freq_test, 3'h0, s.usr.wday[2:0]};
            rtcnv_pkg::OFS_DATE:    rtc_byte = s.usr.date;
            rtcnv_pkg::OFS_MONTH:   rtc_byte = s.usr.mon;
            default:                rtc_byte = s.usr.yr;
        endcase
    endfunction

    logic rd_now;
    logic wr_now;
    logic commit;
    logic rtc_hit;
    logic tick;
    logic [7:0] wd;

    assign rd_now  = !power_fail && !chip_sel_n && !out_en_n && write_en_n;
    assign wr_now  = !power_fail && !chip_sel_n && !write_en_n;
    assign commit  = st_q.wr && !wr_now;
    assign rtc_hit = st_q.waddr >= rtcnv_pkg::OFS_CONTROL;
    assign tick    = !st_q.osc_stop && (st_q.sec_div == 32'(SEC_CYCLES - 1));
    assign wd      = st_q.wdata;

    // memory port: pending write wins the address, else follow the pins
    assign mem_port.we    = commit && !rtc_hit;
    assign mem_port.addr  = commit ? st_q.waddr : addr;
    assign mem_port.wdata = st_q.wdata;

    rtcnv_store #(
        .DEPTH (rtcnv_pkg::MEM_DEPTH)
    ) u_store (
        .sys_clk (sys_clk),
        .port    (mem_port)
    );

    always_comb begin
        st_d = st_q;
        // timekeeping runs regardless of host traffic
        st_d.sec_div = st_q.osc_stop ? st_q.sec_div : (tick ? 32'h0 : st_q.sec_div + 32'h1);
        if (tick) st_d.cnt = advance(st_q.cnt);
        if (st_q.osc_stop || !st_q.freq_test) begin
            st_d.ft_div   = 32'h0;
            st_d.ft_phase = 1'b0;
        end else if (st_q.ft_div == 32'(FT_HALF_CYCLES - 1)) begin
            st_d.ft_div   = 32'h0;
            st_d.ft_phase = !st_q.ft_phase;
        end else begin
            st_d.ft_div = st_q.ft_div + 32'h1;
        end
        // user copy follows the count unless a hold is set
        if (!st_q.load_hold && !st_q.snap_hold) st_d.usr = st_d.cnt;
        // host access capture
        st_d.rd = rd_now;
        st_d.wr = wr_now;
        if (wr_now) begin
            st_d.waddr = addr;
            st_d.wdata = data_in;
        end
        if (commit && rtc_hit) begin
            case (st_q.waddr)
                rtcnv_pkg::OFS_CONTROL: begin
                    st_d.load_hold = wd[rtcnv_pkg::BIT_LOAD_HOLD];
                    st_d.snap_hold = wd[rtcnv_pkg::BIT_SNAP_HOLD];
                    if (st_q.load_hold && !wd[rtcnv_pkg::BIT_LOAD_HOLD] && !wd[rtcnv_pkg::BIT_SNAP_HOLD]) begin
                        st_d.cnt     = st_q.usr;
                        st_d.cnt.cen = {2'h0, wd[5:0]};
                        st_d.usr.cen = {2'h0, wd[5:0]};
                        st_d.sec_div = 32'h0;
                    end else if (!wd[rtcnv_pkg::BIT_LOAD_HOLD] && !wd[rtcnv_pkg::BIT_SNAP_HOLD]
                                 && !st_q.snap_hold) begin
                        st_d.cnt.cen = {2'h0, wd[5:0]};
                        st_d.usr.cen = {2'h0, wd[5:0]};
                    end
                    // setting a hold, or clearing the snapshot hold, keeps century
                end
                rtcnv_pkg::OFS_SECONDS: begin
                    st_d.osc_stop = wd[rtcnv_pkg::BIT_OSC_STOP];
                    st_d.usr.sec  = {1'b0, wd[6:0]};
                end
                rtcnv_pkg::OFS_MINUTES: st_d.usr.min  = wd;
                rtcnv_pkg::OFS_HOURS:   st_d.usr.hr   = wd;
                rtcnv_pkg::OFS_WEEKDAY: begin
                    st_d.freq_test = wd[rtcnv_pkg::BIT_FREQ_TEST];
                    st_d.usr.wday  = {5'h0, wd[2:0]};
                end
                rtcnv_pkg::OFS_DATE:    st_d.usr.date = wd;
                rtcnv_pkg::OFS_MONTH:   st_d.usr.mon  = wd;
                default:                st_d.usr.yr   = wd;
            endcase
        end
        // read path: address and store data line up one clock later
        st_d.raddr = addr;
        st_d.doe   = st_q.rd && rd_now;
        st_d.dout  = (st_q.raddr >= rtcnv_pkg::OFS_CONTROL) ? rtc_byte(st_q.raddr, st_q, battery_ok)
                                                            : mem_port.rdata;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_q          <= '0;
            st_q.cnt.date <= rtcnv_pkg::RST_ONE;
            st_q.cnt.mon  <= rtcnv_pkg::RST_ONE;
            st_q.cnt.wday <= rtcnv_pkg::RST_ONE;
            st_q.usr.date <= rtcnv_pkg::RST_ONE;
            st_q.usr.mon  <= rtcnv_pkg::RST_ONE;
            st_q.usr.wday <= rtcnv_pkg::RST_ONE;
        end else begin
            st_q <= st_d;
        end
    end

    assign data_out = st_q.dout;
    assign data_oe  = st_q.doe;
endmodule

// ===== hdl/rtcnv_pkg.sv
/*
 * constants shared by the clock/calendar core and its byte store.
 * assumes a single clock domain and the fixed 2k byte address map.
 */
package rtcnv_pkg;
    localparam int          ADDR_W       = 11;
    localparam int          DATA_W       = 8;
    localparam int          MEM_DEPTH    = 2048;
    // clock register byte addresses
    localparam logic [10:0] OFS_CONTROL  = 11'h7f8;
    localparam logic [10:0] OFS_SECONDS  = 11'h7f9;
    localparam logic [10:0] OFS_MINUTES  = 11'h7fa;
    localparam logic [10:0] OFS_HOURS    = 11'h7fb;
    localparam logic [10:0] OFS_WEEKDAY  = 11'h7fc;
    localparam logic [10:0] OFS_DATE     = 11'h7fd;
    localparam logic [10:0] OFS_MONTH    = 11'h7fe;
    localparam logic [10:0] OFS_YEAR     = 11'h7ff;
    // field positions
    localparam int          BIT_LOAD_HOLD = 7;
    localparam int          BIT_SNAP_HOLD = 6;
    localparam int          BIT_OSC_STOP  = 7;
    localparam int          BIT_FREQ_TEST = 6;
    localparam int          BIT_BATT_FLAG = 7;
    // bcd limits
    localparam logic [7:0]  MAX_SEC      = 8'h59;
    localparam logic [7:0]  MAX_MIN      = 8'h59;
    localparam logic [7:0]  MAX_HOUR     = 8'h23;
    localparam logic [7:0]  MAX_WDAY     = 8'h07;
    localparam logic [7:0]  MAX_MONTH    = 8'h12;
    localparam logic [7:0]  MAX_YEAR     = 8'h99;
    localparam logic [7:0]  MAX_CENT     = 8'h39;
    // reset values
    localparam logic [7:0]  RST_ZERO     = 8'h00;
    localparam logic [7:0]  RST_ONE      = 8'h01;
    // timing
    localparam int          CLK_HZ       = 100_000_000;
    localparam int          TICK_HZ      = 1;
    localparam int          FT_HZ        = 512;
    localparam int          SEC_CYCLES   = CLK_HZ / TICK_HZ;
    localparam int          FT_HALF_CYCLES = CLK_HZ / (2 * FT_HZ);
endpackage

// ===== hdl/rtcnv_mem_if.sv
/*
 * port between the access logic and the byte store.
 * assumes the store answers with registered read data one clock later.
 */
`timescale 1ns/1ps
interface rtcnv_mem_if;
    logic        we;
    logic [10:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem  (input we, input addr, input wdata, output rdata);
endinterface

// ===== hdl/rtcnv_store.sv
/*
 * byte store behind the parallel port, read data registered.
 * assumes battery backing, so the array has no reset.
 */
`timescale 1ns/1ps
module rtcnv_store #(
    parameter int DEPTH = rtcnv_pkg::MEM_DEPTH
) (
    // clock
    input  wire logic sys_clk,
    // access port
    rtcnv_mem_if.mem  port
);
    logic [7:0] mem_q [DEPTH];
    logic [7:0] rdata_q;

    initial begin
        if (DEPTH != rtcnv_pkg::MEM_DEPTH) $error("store depth must be 2048");
    end

    always_ff @(posedge sys_clk) begin
        if (port.we) begin
            mem_q[port.addr] <= port.wdata;
        end
        rdata_q <= mem_q[port.addr];
    end

    assign port.rdata = rdata_q;
endmodule

// ===== test/rtcnv_checker.sv
/* assertions on the host pins of the clock core.
   assumes it is bound into rtcnv_top and sees only its ports. */
`timescale 1ns/1ps
module rtcnv_checker #(
    parameter int SEC_CYCLES     = rtcnv_pkg::SEC_CYCLES,
    parameter int FT_HALF_CYCLES = rtcnv_pkg::FT_HALF_CYCLES
) (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        reset,
    // host port
    input wire logic [10:0] addr,
    input wire logic        chip_sel_n,
    input wire logic        out_en_n,
    input wire logic        write_en_n,
    input wire logic [7:0]  data_in,
    input wire logic [7:0]  data_out,
    input wire logic        data_oe,
    // supply and battery status
    input wire logic        power_fail,
    input wire logic        battery_ok
);
    logic rd;
    assign rd = !chip_sel_n && !out_en_n && write_en_n && !power_fail;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_read_drives: assert property (rd && $past(rd) |=> data_oe) else $error("read not driven");
    a_read_release: assert property (!rd |=> !data_oe) else $error("output left on");
    a_oe_cause: assert property ($rose(data_oe) |-> $past(rd) && $past(rd, 2)) else $error("stray drive");
    a_oe_stands: assert property (data_oe && rd |=> data_oe) else $error("output dropped in read");
    a_fail_quiet: assert property (power_fail |=> !data_oe) else $error("drive in power fail");
    a_strobe_quiet: assert property (!chip_sel_n && !write_en_n |=> !data_oe) else $error("drive in write");
    a_batt_flag: assert property ((rd && addr == rtcnv_pkg::OFS_WEEKDAY)[*3] ##0 battery_ok == $past(battery_ok, 2)
        |=> data_out[7] == $past(battery_ok)) else $error("battery flag wrong");
    a_ram_steady: assert property (rd && $past(rd) && $past(rd, 2) && addr == $past(addr) && addr == $past(addr, 2)
        && addr < rtcnv_pkg::OFS_CONTROL |=> $stable(data_out)) else $error("store byte moved");
    c_seconds_read: cover property (rd && data_oe && addr == rtcnv_pkg::OFS_SECONDS);
    c_ctl_write: cover property (!chip_sel_n && !write_en_n && addr == rtcnv_pkg::OFS_CONTROL);
    c_fail_access: cover property (power_fail && !chip_sel_n);
endmodule
bind rtcnv_top rtcnv_checker #(.SEC_CYCLES(SEC_CYCLES), .FT_HALF_CYCLES(FT_HALF_CYCLES)) u_chk (.sys_clk(sys_clk),
    .reset(reset), .addr(addr), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .power_fail(power_fail), .battery_ok(battery_ok));

// ===== test/rtcnv_host.sv
/* host processor model on the byte-wide port.
   assumes pins change at the falling edge of sys_clk. */
`timescale 1ns/1ps
module rtcnv_host (
    // clock
    input  wire logic        sys_clk,
    // host pins
    output logic      [10:0] addr,
    output logic             chip_sel_n,
    output logic             out_en_n,
    output logic             write_en_n,
    output logic      [7:0]  data_in,
    // device answer
    input  wire logic [7:0]  data_out,
    input  wire logic        data_oe
);
    initial begin
        addr       = 11'h000;
        chip_sel_n = 1'b1;
        out_en_n   = 1'b1;
        write_en_n = 1'b1;
        data_in    = 8'h00;
    end
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        addr       = a;
        data_in    = d;
        chip_sel_n = 1'b0;
        write_en_n = 1'b0;
        @(negedge sys_clk);
        chip_sel_n = 1'b1;
        write_en_n = 1'b1;
        // released bus shows no stale byte
        data_in    = ~d;
    endtask
    // read held n extra cycles, counting lsb changes
    task automatic rd(input logic [10:0] a, input int n, output logic [7:0] d, output logic oe, output int tg);
        logic [7:0] p;
        @(negedge sys_clk);
        addr       = a;
        chip_sel_n = 1'b0;
        out_en_n   = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        d  = data_out;
        oe = data_oe;
        p  = d;
        tg = 0;
        repeat (n) begin
            @(posedge sys_clk);
            #1;
            tg += int'(data_out[0] !== p[0]);
            p = data_out;
        end
        @(negedge sys_clk);
        chip_sel_n = 1'b1;
        out_en_n   = 1'b1;
    endtask
endmodule

// ===== test/test_rtcnv.sv
/* self-checking bench for the clock core and byte store.
   assumes short second and test-toggle counts set through parameters. */
`timescale 1ns/1ps
module test_rtcnv;
    localparam int          SC  = 40;
    localparam logic [10:0] CTL = rtcnv_pkg::OFS_CONTROL;
    logic        sys_clk, reset, power_fail, battery_ok, oe, chip_sel_n, out_en_n, write_en_n, data_oe;
    logic [10:0] addr, a;
    logic [7:0]  data_in, data_out, v, s0, cent;
    int          err_count, n_checks, tg, k;
    rtcnv_top #(.SEC_CYCLES(SC), .FT_HALF_CYCLES(4)) dut (.sys_clk(sys_clk), .reset(reset), .addr(addr),
        .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_en_n(write_en_n), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .power_fail(power_fail), .battery_ok(battery_ok));
    rtcnv_host host (.sys_clk(sys_clk), .addr(addr), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
        .write_en_n(write_en_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rr(input logic [10:0] ra, input logic [7:0] exp);
        host.rd(ra, 1, v, oe, tg);
        chk({7'h0, oe}, 8'h01);
        chk(v, exp);
    endtask
    function automatic logic [7:0] inc(input logic [7:0] x);
        return (x[3:0] == 4'h9) ? {x[7:4] + 4'h1, 4'h0} : x + 8'h01;
    endfunction
    // seconds in bcd to plain count, stop bit dropped
    function automatic int bcd2i(input logic [7:0] x);
        return 10 * int'(x[6:4]) + int'(x[3:0]);
    endfunction
    function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
        if (m == 8'h02)
            return ((10 * y[7:4] + y[3:0]) % 4 == 0) ? 8'h29 : 8'h28;
        return (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) ? 8'h30 : 8'h31;
    endfunction
    // load 23:59:59 on the last day of month m, expect the next day after one tick
    task automatic roll(input logic [7:0] m, input logic [7:0] y);
        logic [7:0] w[8];
        logic [7:0] e[8];
        logic       wrap;
        wrap = (m == 8'h12 && y == 8'h99);
        w = '{8'h20, 8'h59, 8'h59, 8'h23, 8'h07, last_day(m, y), m, y};
        e = '{wrap ? 8'h21 : 8'h20, 8'h00, 8'h00, 8'h00, {battery_ok, 7'h01}, 8'h01,
              (m == 8'h12) ? 8'h01 : inc(m), (m == 8'h12) ? (wrap ? 8'h00 : inc(y)) : y};
        host.wr(CTL, 8'h95);
        rr(CTL, 8'h80 | cent);
        for (int i = 7; i >= 0; i--) host.wr(CTL + 11'(i), w[i]);
        repeat (SC + 2) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) rr(CTL + 11'(i), e[i]);
        cent = e[0];
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        #200000;
        err_count++;
        report_and_stop;
    end
    initial begin
        reset = 1'b1;
        power_fail = 1'b0;
        battery_ok = 1'b1;
        err_count = 0;
        n_checks = 0;
        cent = 8'h00;
        void'($urandom(42));
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'b0;
        rr(rtcnv_pkg::OFS_WEEKDAY, 8'h81);
        battery_ok = 1'b0;
        rr(rtcnv_pkg::OFS_WEEKDAY, 8'h01);
        battery_ok = 1'b1;
        $display("reset and battery flag done");
        roll(8'h02, 8'h24);
        roll(8'h02, 8'h23);
        roll(8'h12, 8'h99);
        for (int i = 0; i < 5; i++) begin
            k = $urandom_range(12, 1);
            roll(8'(k < 10 ? k : k + 6), {4'($urandom_range(9)), 4'($urandom_range(9))});
        end
        $display("calendar rollover done");
        host.wr(CTL, 8'h45);
        host.rd(rtcnv_pkg::OFS_SECONDS, 0, s0, oe, tg);
        repeat (2 * SC + 5) @(negedge sys_clk);
        rr(rtcnv_pkg::OFS_SECONDS, s0);
        host.wr(CTL, 8'h00);
        repeat (4) @(negedge sys_clk);
        rr(CTL, cent);
        host.rd(rtcnv_pkg::OFS_SECONDS, 0, v, oe, tg);
        chk({7'h0, ((bcd2i(v) - bcd2i(s0) + 60) % 60) inside {[2:3]}}, 8'h01);
        host.wr(CTL, 8'h05);
        rr(CTL, 8'h05);
        $display("snapshot hold done");
        host.wr(rtcnv_pkg::OFS_WEEKDAY, 8'h41);
        host.rd(rtcnv_pkg::OFS_SECONDS, 32, v, oe, tg);
        chk({7'h0, tg inside {[6:10]}}, 8'h01);
        host.wr(rtcnv_pkg::OFS_WEEKDAY, 8'h01);
        host.rd(rtcnv_pkg::OFS_SECONDS, 32, v, oe, tg);
        chk({7'h0, tg < 2}, 8'h01);
        host.wr(rtcnv_pkg::OFS_SECONDS, 8'h80);
        host.rd(rtcnv_pkg::OFS_SECONDS, 0, s0, oe, tg);
        repeat (3 * SC) @(negedge sys_clk);
        rr(rtcnv_pkg::OFS_SECONDS, s0);
        host.wr(rtcnv_pkg::OFS_SECONDS, 8'h00);
        repeat (3 * SC) @(negedge sys_clk);
        host.rd(rtcnv_pkg::OFS_SECONDS, 0, v, oe, tg);
        chk({7'h0, v[6:0] !== s0[6:0]}, 8'h01);
        $display("test toggle and stop done");
        for (int i = 0; i < 8; i++) begin
            a = 11'($urandom_range(2039));
            s0 = 8'($urandom);
            host.wr(a, s0);
            @(negedge sys_clk);
            power_fail = 1'b1;
            host.wr(a, ~s0);
            host.rd(a, 0, v, oe, tg);
            chk({7'h0, oe}, 8'h00);
            power_fail = 1'b0;
            rr(a, s0);
        end
        $display("store and power fail done");
        report_and_stop;
    end
endmodule
